// ### src/irq_bank_pkg.sv
// Package: register layout, field positions and shared types of the interrupt bank
`default_nettype none
package irq_bank_pkg;
	// Register indices on the data-memory port (no printed addresses; chosen locally)
	localparam logic [2:0] REG_EDGE = 3'h0;
	localparam logic [2:0] REG_PRI0 = 3'h1;
	localparam logic [2:0] REG_PRI1 = 3'h2;
	localparam logic [2:0] REG_PRI2 = 3'h3;
	localparam logic [2:0] REG_GRP0 = 3'h4;
	localparam logic [2:0] REG_GRP1 = 3'h5;
	localparam logic [2:0] REG_GRP2 = 3'h6;
	localparam int NUM_REGS = 7;

	// Implemented-bit masks per register
	localparam logic [7:0] MASK_EDGE = 8'h0f;
	localparam logic [7:0] MASK_PRI0 = 8'h7f;
	localparam logic [7:0] MASK_PRI1 = 8'hff;
	localparam logic [7:0] MASK_PRI2 = 8'h77;
	localparam logic [7:0] MASK_GRP = 8'h33;
	localparam logic [7:0] RESET_VAL = 8'h00;

	// Field positions
	localparam int EDGE_PIN0_LSB = 0;
	localparam int EDGE_PIN1_LSB = 2;
	localparam int P0_ADC_REQ = 6;
	localparam int P0_PIN1_REQ = 5;
	localparam int P0_PIN0_REQ = 4;
	localparam int P0_ADC_EN = 3;
	localparam int P0_PIN1_EN = 2;
	localparam int P0_PIN0_EN = 1;
	localparam int P0_GLOBAL_EN = 0;
	localparam int P1_UART_REQ = 7;
	localparam int P1_GRP_REQ_LSB = 4;
	localparam int P1_UART_EN = 3;
	localparam int P1_GRP_EN_LSB = 0;
	localparam int P2_TB1_REQ = 6;
	localparam int P2_TB0_REQ = 5;
	localparam int P2_SPI_REQ = 4;
	localparam int P2_TB1_EN = 2;
	localparam int P2_TB0_EN = 1;
	localparam int P2_SPI_EN = 0;
	localparam int G_REQ_HI = 5;
	localparam int G_REQ_LO = 4;
	localparam int G_EN_HI = 1;
	localparam int G_EN_LO = 0;

	// Edge select codes
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Vector identities, in priority order
	typedef enum logic [3:0] {
		VEC_NONE = 4'h0,
		VEC_PIN0 = 4'h1,
		VEC_PIN1 = 4'h2,
		VEC_ADC = 4'h3,
		VEC_GRP0 = 4'h4,
		VEC_GRP1 = 4'h5,
		VEC_GRP2 = 4'h6,
		VEC_UART = 4'h7,
		VEC_SPI = 4'h8,
		VEC_TB0 = 4'h9,
		VEC_TB1 = 4'ha
	} vector_t;

	// Peripheral event pulses
	typedef struct packed {
		logic adc_done;
		logic uart;
		logic spi;
		logic timebase0;
		logic timebase1;
		logic timer0_cmpa;
		logic timer0_period;
		logic timer1_cmpa;
		logic timer1_period;
		logic eeprom_write_done;
		logic low_voltage;
	} periph_events_t;

	// Register access from the core
	typedef struct packed {
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage : irq_bank_pkg
`default_nettype wire

// ### src/ext_edge_detect.sv
// Edge detector for one external interrupt pin with a selectable trigger edge
`default_nettype none
module ext_edge_detect
	import irq_bank_pkg::*;
(
	input wire logic sys_clk_in, // System clock
	input wire logic srst_in, // Synchronous reset, active high
	input wire logic pin_in, // Pin level, synchronous
	input wire logic [1:0] edge_sel_in, // Trigger edge code
	output logic hit_out // One-cycle pulse on selected edge
);
	logic prev_q;
	logic rise;
	logic fall;

	// Previous level, reset low so a high pin at release reads as a rising edge only when selected
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
			prev_q <= 1'b0;
		else
			prev_q <= pin_in;
	end

	assign rise = pin_in & ~prev_q;
	assign fall = ~pin_in & prev_q;

	// Code decode; zero turns detection off
	always_comb
	begin
		unique case (edge_sel_in)
			EDGE_OFF: hit_out = 1'b0;
			EDGE_RISE: hit_out = rise;
			EDGE_FALL: hit_out = fall;
			EDGE_BOTH: hit_out = rise | fall;
		endcase
	end
endmodule : ext_edge_detect
`default_nettype wire

// ### src/mcu_interrupt_flag_enable_bank.sv
// Interrupt flag and enable register bank with request arbitration
// Contract
// RQ1: Three primary, three group, one edge register
// RQ2: Hardware sets flags; program writes enables
// RQ3: Pin 1 edge code in bits 3..2
// RQ4: Pin 0 edge code in bits 1..0
// RQ5: Primary 0 flags: ADC6, pin1 5, pin0 4
// RQ6: Primary 0 enables: ADC3, pin1 2, pin0 1, global0
// RQ7: Primary 1: UART and group flags, enables
// RQ8: Primary 2: timebase and SPI flags, enables
// RQ9: Group 0 holds timer 0 requests, enables
// RQ10: Group 1 mirrors group 0 for timer 1
// RQ11: Group 2 holds EEPROM and low-voltage bits
// RQ12: Unimplemented bits read zero, ignore writes
// RQ13: Flags one when pending; all reset zero
// RQ14: Disabled flag still sets; global enable gates all
// RQ15: Servicing clears global enable, flags still record
// RQ16: Servicing pin or ADC clears its flag
// RQ17: Group service clears group flag only; an enabled pending member flag sets it again in the same cycle
// RQ18: Group flag set by enabled member flag
// RQ19: Software writes to flags take effect directly
`default_nettype none
module mcu_interrupt_flag_enable_bank
	import irq_bank_pkg::*;
(
	input wire logic sys_clk_in, // System clock, 200 MHz
	input wire logic srst_in, // Synchronous reset, active high
	input wire irq_bank_pkg::reg_req_t reg_req_in, // Core register access
	input wire logic reg_rd_in, // Core read strobe
	input wire irq_bank_pkg::periph_events_t events_in, // Peripheral event pulses
	input wire logic ext_pin_0_in, // External pin 0 level
	input wire logic ext_pin_1_in, // External pin 1 level
	input wire logic stack_full_in, // Core cannot take a vector now
	input wire logic vector_ack_in, // Core takes the offered vector
	output logic [7:0] reg_rdata_out, // Read data, one cycle after strobe
	output irq_bank_pkg::vector_t vector_out, // Highest pending vector
	output logic irq_req_out // Vector jump requested
);
	// Register state (see RQ1)
	logic [7:0] edge_q;
	logic [7:0] pri0_q;
	logic [7:0] pri1_q;
	logic [7:0] pri2_q;
	logic [7:0] grp0_q;
	logic [7:0] grp1_q;
	logic [7:0] grp2_q;
	logic [7:0] edge_d;
	logic [7:0] pri0_d;
	logic [7:0] pri1_d;
	logic [7:0] pri2_d;
	logic [7:0] grp0_d;
	logic [7:0] grp1_d;
	logic [7:0] grp2_d;
	logic [7:0] rdata_d;
	logic [1:0] pin_hit;
	logic [2:0] grp_member;
	vector_t vec_d;
	vector_t vec_q;
	logic req_q;
	logic service;

	// Write enable per register
	function automatic logic wr_hit(input reg_req_t req, input logic [2:0] idx);
		wr_hit = req.wr && (req.addr == idx);
	endfunction : wr_hit

	// Masked write merge; unimplemented bits stay zero (see RQ12)
	function automatic logic [7:0] merge(input logic [7:0] cur, input reg_req_t req,
		input logic [2:0] idx, input logic [7:0] mask);
		merge = wr_hit(req, idx) ? (req.wdata & mask) : cur;
	endfunction : merge

	// Edge detectors, one per external pin (see RQ3) (see RQ4)
	ext_edge_detect u_pin0 (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.pin_in(ext_pin_0_in),
		.edge_sel_in(edge_q[EDGE_PIN0_LSB +: 2]),
		.hit_out(pin_hit[0])
	);
	ext_edge_detect u_pin1 (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.pin_in(ext_pin_1_in),
		.edge_sel_in(edge_q[EDGE_PIN1_LSB +: 2]),
		.hit_out(pin_hit[1])
	);

	// Group member requests: any member flag with its own enable (see RQ18)
	assign grp_member[0] = (grp0_q[G_REQ_HI] & grp0_q[G_EN_HI]) | (grp0_q[G_REQ_LO] & grp0_q[G_EN_LO]);
	assign grp_member[1] = (grp1_q[G_REQ_HI] & grp1_q[G_EN_HI]) | (grp1_q[G_REQ_LO] & grp1_q[G_EN_LO]);
	assign grp_member[2] = (grp2_q[G_REQ_HI] & grp2_q[G_EN_HI]) | (grp2_q[G_REQ_LO] & grp2_q[G_EN_LO]);

	// A vector is consumed only while one is offered
	assign service = vector_ack_in & req_q;

	// Priority choice among enabled pending requests; global enable gates all (see RQ14)
	always_comb
	begin
		vec_d = VEC_NONE;
		if (pri0_q[P0_GLOBAL_EN] && !stack_full_in)
		begin
			if (pri0_q[P0_PIN0_REQ] && pri0_q[P0_PIN0_EN])
				vec_d = VEC_PIN0;
			else if (pri0_q[P0_PIN1_REQ] && pri0_q[P0_PIN1_EN])
				vec_d = VEC_PIN1;
			else if (pri0_q[P0_ADC_REQ] && pri0_q[P0_ADC_EN])
				vec_d = VEC_ADC;
			else if (pri1_q[P1_GRP_REQ_LSB] && pri1_q[P1_GRP_EN_LSB])
				vec_d = VEC_GRP0;
			else if (pri1_q[P1_GRP_REQ_LSB + 1] && pri1_q[P1_GRP_EN_LSB + 1])
				vec_d = VEC_GRP1;
			else if (pri1_q[P1_GRP_REQ_LSB + 2] && pri1_q[P1_GRP_EN_LSB + 2])
				vec_d = VEC_GRP2;
			else if (pri1_q[P1_UART_REQ] && pri1_q[P1_UART_EN])
				vec_d = VEC_UART;
			else if (pri2_q[P2_SPI_REQ] && pri2_q[P2_SPI_EN])
				vec_d = VEC_SPI;
			else if (pri2_q[P2_TB0_REQ] && pri2_q[P2_TB0_EN])
				vec_d = VEC_TB0;
			else if (pri2_q[P2_TB1_REQ] && pri2_q[P2_TB1_EN])
				vec_d = VEC_TB1;
		end
	end

	// Edge register: software only
	assign edge_d = merge(edge_q, reg_req_in, REG_EDGE, MASK_EDGE); // see RQ12

	// Primary 0: write, then service clears, then hardware sets win (see RQ5) (see RQ6)
	always_comb
	begin
		pri0_d = merge(pri0_q, reg_req_in, REG_PRI0, MASK_PRI0); // see RQ19
		if (service)
		begin
			pri0_d[P0_GLOBAL_EN] = 1'b0; // see RQ15
			if (vec_q == VEC_PIN0)
				pri0_d[P0_PIN0_REQ] = 1'b0; // see RQ16
			if (vec_q == VEC_PIN1)
				pri0_d[P0_PIN1_REQ] = 1'b0; // see RQ16
			if (vec_q == VEC_ADC)
				pri0_d[P0_ADC_REQ] = 1'b0; // see RQ16
		end
		// Set beats a same-cycle clear so no event is lost (see RQ2) (see RQ14)
		if (pin_hit[0])
			pri0_d[P0_PIN0_REQ] = 1'b1;
		if (pin_hit[1])
			pri0_d[P0_PIN1_REQ] = 1'b1;
		if (events_in.adc_done)
			pri0_d[P0_ADC_REQ] = 1'b1;
	end

	// Primary 1: UART and group flags (see RQ7)
	always_comb
	begin
		pri1_d = merge(pri1_q, reg_req_in, REG_PRI1, MASK_PRI1); // see RQ19
		if (service)
		begin
			// Group flag clear is overridden below while an enabled member flag is pending; member flags are left for the program (see RQ17)
			if (vec_q == VEC_GRP0)
				pri1_d[P1_GRP_REQ_LSB] = 1'b0;
			if (vec_q == VEC_GRP1)
				pri1_d[P1_GRP_REQ_LSB + 1] = 1'b0;
			if (vec_q == VEC_GRP2)
				pri1_d[P1_GRP_REQ_LSB + 2] = 1'b0;
			if (vec_q == VEC_UART)
				pri1_d[P1_UART_REQ] = 1'b0;
		end
		for (int g = 0; g < 3; g++)
		begin
			if (grp_member[g])
				pri1_d[P1_GRP_REQ_LSB + g] = 1'b1; // see RQ18
		end
		if (events_in.uart)
			pri1_d[P1_UART_REQ] = 1'b1; // see RQ2
	end

	// Primary 2: SPI and time bases (see RQ8)
	always_comb
	begin
		pri2_d = merge(pri2_q, reg_req_in, REG_PRI2, MASK_PRI2); // see RQ19
		if (service)
		begin
			if (vec_q == VEC_SPI)
				pri2_d[P2_SPI_REQ] = 1'b0;
			if (vec_q == VEC_TB0)
				pri2_d[P2_TB0_REQ] = 1'b0;
			if (vec_q == VEC_TB1)
				pri2_d[P2_TB1_REQ] = 1'b0;
		end
		if (events_in.spi)
			pri2_d[P2_SPI_REQ] = 1'b1; // see RQ2
		if (events_in.timebase0)
			pri2_d[P2_TB0_REQ] = 1'b1;
		if (events_in.timebase1)
			pri2_d[P2_TB1_REQ] = 1'b1;
	end

	// Group registers: member flags cleared by software only (see RQ9) (see RQ10) (see RQ11)
	always_comb
	begin
		grp0_d = merge(grp0_q, reg_req_in, REG_GRP0, MASK_GRP);
		grp1_d = merge(grp1_q, reg_req_in, REG_GRP1, MASK_GRP);
		grp2_d = merge(grp2_q, reg_req_in, REG_GRP2, MASK_GRP);
		if (events_in.timer0_cmpa)
			grp0_d[G_REQ_HI] = 1'b1; // see RQ2
		if (events_in.timer0_period)
			grp0_d[G_REQ_LO] = 1'b1;
		if (events_in.timer1_cmpa)
			grp1_d[G_REQ_HI] = 1'b1;
		if (events_in.timer1_period)
			grp1_d[G_REQ_LO] = 1'b1;
		if (events_in.eeprom_write_done)
			grp2_d[G_REQ_HI] = 1'b1;
		if (events_in.low_voltage)
			grp2_d[G_REQ_LO] = 1'b1;
	end

	// Register update; all implemented bits clear at reset (see RQ13)
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
		begin
			edge_q <= RESET_VAL;
			pri0_q <= RESET_VAL;
			pri1_q <= RESET_VAL;
			pri2_q <= RESET_VAL;
			grp0_q <= RESET_VAL;
			grp1_q <= RESET_VAL;
			grp2_q <= RESET_VAL;
		end
		else
		begin
			edge_q <= edge_d;
			pri0_q <= pri0_d;
			pri1_q <= pri1_d;
			pri2_q <= pri2_d;
			grp0_q <= grp0_d;
			grp1_q <= grp1_d;
			grp2_q <= grp2_d;
		end
	end

	// Read mux; stored values already hold zero in unused bits (see RQ12) (see RQ13)
	always_comb
	begin
		rdata_d = 8'h00;
		if (reg_rd_in)
		begin
			unique case (reg_req_in.addr)
				REG_EDGE: rdata_d = edge_q;
				REG_PRI0: rdata_d = pri0_q;
				REG_PRI1: rdata_d = pri1_q;
				REG_PRI2: rdata_d = pri2_q;
				REG_GRP0: rdata_d = grp0_q;
				REG_GRP1: rdata_d = grp1_q;
				REG_GRP2: rdata_d = grp2_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
			reg_rdata_out <= 8'h00;
		else
			reg_rdata_out <= rdata_d;
	end

	// Vector offer; dropped right after acknowledge so the same request is not taken twice
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in || service)
		begin
			vec_q <= VEC_NONE;
			req_q <= 1'b0;
		end
		else
		begin
			vec_q <= vec_d;
			req_q <= (vec_d != VEC_NONE); // see RQ14
		end
	end

	assign vector_out = vec_q;
	assign irq_req_out = req_q;
endmodule : mcu_interrupt_flag_enable_bank
`default_nettype wire

// ### verif/irq_bank_monitor.sv
// Port-level assertions for the interrupt bank
`default_nettype none
module irq_bank_monitor
	import irq_bank_pkg::*;
(
	input wire logic sys_clk_in, // Clock
	input wire logic srst_in, // Reset
	input wire irq_bank_pkg::reg_req_t reg_req_in, // Access
	input wire logic reg_rd_in, // Read strobe
	input wire irq_bank_pkg::periph_events_t events_in, // Events
	input wire logic ext_pin_0_in, // Pin 0
	input wire logic ext_pin_1_in, // Pin 1
	input wire logic stack_full_in, // Stack full
	input wire logic vector_ack_in, // Take pulse
	input wire logic [7:0] reg_rdata_out, // Read data
	input wire irq_bank_pkg::vector_t vector_out, // Vector
	input wire logic irq_req_out // Jump request
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	// Plain read without a write beside it, and a write
	sequence s_rd(logic [2:0] a);
		reg_rd_in && !reg_req_in.wr && reg_req_in.addr == a;
	endsequence
	sequence s_wr(logic [2:0] a);
		reg_req_in.wr && reg_req_in.addr == a;
	endsequence
	a_edge_round_trip: assert property (
		s_wr(REG_EDGE) ##1 s_rd(REG_EDGE) |=> reg_rdata_out == ($past(reg_req_in.wdata, 2) & MASK_EDGE))
		else $error("edge select readback wrong");
	a_pri0_top_zero: assert property (s_rd(REG_PRI0) |=> !reg_rdata_out[7])
		else $error("primary 0 bit 7 not zero");
	a_pri2_gaps_zero: assert property (s_rd(REG_PRI2) |=> (reg_rdata_out & ~MASK_PRI2) == 8'h00)
		else $error("primary 2 gap bits not zero");
	a_grp_gaps_zero: assert property (
		reg_rd_in && reg_req_in.addr >= REG_GRP0 && reg_req_in.addr <= REG_GRP2 |=> (reg_rdata_out & ~MASK_GRP) == 8'h00)
		else $error("group gap bits not zero");
	a_unmapped_zero: assert property (s_rd(3'h7) |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_req_has_vec: assert property (irq_req_out |-> vector_out != VEC_NONE)
		else $error("request without vector");
	a_take_drops_req: assert property (vector_ack_in && irq_req_out |=> !irq_req_out)
		else $error("request stays after take");
	a_full_holds_off: assert property (stack_full_in && !irq_req_out |=> !irq_req_out)
		else $error("request while stack full");
	a_vec_held: assert property (irq_req_out && !vector_ack_in |=> irq_req_out && $stable(vector_out))
		else $error("vector moved before take");
endmodule : irq_bank_monitor
bind mcu_interrupt_flag_enable_bank irq_bank_monitor mon (.sys_clk_in, .srst_in, .reg_req_in, .reg_rd_in,
	.events_in, .ext_pin_0_in, .ext_pin_1_in, .stack_full_in, .vector_ack_in, .reg_rdata_out, .vector_out,
	.irq_req_out);
`default_nettype wire

// ### verif/cpu_core_model.sv
// Core-side model that takes an offered vector after a set delay
`default_nettype none
module cpu_core_model
(
	input wire logic sys_clk_in, // Clock
	input wire logic srst_in, // Reset
	input wire logic irq_req_in, // Jump request
	input wire logic [3:0] delay_in, // Cycles before taking
	output logic vector_ack_out // One-cycle take pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	// Takes only while asked; re-arms after each pulse so one request gets one take
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in || vector_ack_out || !irq_req_in)
		begin
			vector_ack_out <= 1'b0;
			wait_q <= 4'h0;
		end
		else if (wait_q == delay_in)
			vector_ack_out <= 1'b1;
		else
			wait_q <= wait_q + 4'h1;
	end
endmodule : cpu_core_model
`default_nettype wire

// ### verif/mcu_interrupt_flag_enable_bank_tb.sv
// Directed tests of the interrupt flag and enable bank
`default_nettype none
module mcu_interrupt_flag_enable_bank_tb;
	import irq_bank_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	reg_req_t req = '0;
	logic rd = 1'b0;
	periph_events_t ev = '0;
	logic [1:0] pins = 2'h0;
	logic full = 1'b0;
	logic [3:0] dly = 4'h0;
	logic ack;
	logic [7:0] rdata;
	vector_t vec;
	logic irq;
	int errors = 0;
	int checked = 0;
	localparam logic [7:0] MASKS [7] = '{MASK_EDGE, MASK_PRI0, MASK_PRI1, MASK_PRI2, MASK_GRP, MASK_GRP, MASK_GRP};
	// 200 MHz clock
	always #2.5 sys_clk_in = ~sys_clk_in;
	mcu_interrupt_flag_enable_bank dut (.sys_clk_in, .srst_in, .reg_req_in(req), .reg_rd_in(rd), .events_in(ev),
		.ext_pin_0_in(pins[0]), .ext_pin_1_in(pins[1]), .stack_full_in(full), .vector_ack_in(ack),
		.reg_rdata_out(rdata), .vector_out(vec), .irq_req_out(irq));
	cpu_core_model core (.sys_clk_in, .srst_in, .irq_req_in(irq), .delay_in(dly), .vector_ack_out(ack));
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chkv(input vector_t got, input vector_t exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t: vector %0d, expected %0d", $time, got, exp);
		end
	endtask : chkv
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : idle
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		req = {1'b1, a, d};
		idle(1);
		req.wr = 1'b0;
	endtask : wr
	// Data lands one cycle after the strobe edge
	task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
		rd = 1'b1;
		req.addr = a;
		idle(1);
		rd = 1'b0;
		chk8(rdata, exp);
	endtask : rdc
	task automatic pulse(input periph_events_t e);
		ev = e;
		idle(1);
		ev = '0;
	endtask : pulse
	// Bounded wait for a jump request
	task automatic wait_irq;
		for (int i = 0; i < 50 && irq !== 1'b1; i++)
			idle(1);
		chk8({7'h0, irq}, 8'h01);
	endtask : wait_irq
	task automatic test_done;
		$display("compares %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (5000) @(posedge sys_clk_in);
		errors++;
		$display("FAIL %0t: timeout", $time);
		test_done();
	end
	initial
	begin
		idle(8);
		srst_in = 1'b0;
		for (int i = 0; i < 8; i++)
			rdc(3'(i), 8'h00);
		$display("test reset done");
		// Stack held full so the all-ones write cannot launch a jump
		full = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			wr(3'(i), 8'hff);
			rdc(3'(i), (i < 7) ? MASKS[i] : 8'h00);
			wr(3'(i), 8'h00);
		end
		wr(REG_PRI1, 8'h00);
		full = 1'b0;
		$display("test masks done");
		// All peripheral events fire with enables off, pins held still: flags only, no jump
		pulse('1);
		rdc(REG_PRI0, 8'h40);
		rdc(REG_PRI1, 8'h80);
		rdc(REG_PRI2, 8'h70);
		rdc(REG_GRP0, 8'h30);
		rdc(REG_GRP1, 8'h30);
		rdc(REG_GRP2, 8'h30);
		chk8({7'h0, irq}, 8'h00);
		for (int i = 1; i < 7; i++)
			wr(3'(i), 8'h00);
		$display("test events done");
		// Every edge code on both pins, rise then fall
		for (int p = 0; p < 2; p++)
			for (int c = 0; c < 4; c++)
			begin
				wr(REG_EDGE, 8'(c << (2 * p)));
				pins[p] = 1'b1;
				idle(2);
				rdc(REG_PRI0, 8'((c % 2) << (4 + p)));
				wr(REG_PRI0, 8'h00);
				pins[p] = 1'b0;
				idle(2);
				rdc(REG_PRI0, 8'((c / 2) << (4 + p)));
				wr(REG_PRI0, 8'h00);
			end
		$display("test edges done");
		// Pin 0 jump taken at once
		wr(REG_EDGE, 8'h01);
		wr(REG_PRI0, 8'h03);
		pins[0] = 1'b1;
		wait_irq();
		chkv(vec, VEC_PIN0);
		idle(4);
		rdc(REG_PRI0, 8'h02);
		pins[0] = 1'b0;
		// Converter request held off by a full stack, then taken slowly
		full = 1'b1;
		dly = 4'h5;
		wr(REG_PRI0, 8'h09);
		pulse('{adc_done: 1'b1, default: 1'b0});
		idle(3);
		chk8({7'h0, irq}, 8'h00);
		full = 1'b0;
		wait_irq();
		chkv(vec, VEC_ADC);
		idle(10);
		rdc(REG_PRI0, 8'h08);
		$display("test vectors done");
		// Low-voltage source through group 2; program clears the member
		wr(REG_GRP2, 8'h03);
		wr(REG_PRI1, 8'h04);
		wr(REG_PRI0, 8'h01);
		pulse('{low_voltage: 1'b1, default: 1'b0});
		wait_irq();
		chkv(vec, VEC_GRP2);
		idle(10);
		rdc(REG_GRP2, 8'h13);
		rdc(REG_PRI0, 8'h00);
		wr(REG_GRP2, 8'h03);
		wr(REG_PRI1, 8'h04);
		rdc(REG_PRI1, 8'h04);
		$display("test group done");
		// UART and SPI pending together: UART ranks first, SPI stays pending
		wr(REG_PRI2, 8'h01);
		wr(REG_PRI1, 8'h08);
		pulse('{uart: 1'b1, spi: 1'b1, default: 1'b0});
		wr(REG_PRI0, 8'h01);
		wait_irq();
		chkv(vec, VEC_UART);
		idle(10);
		rdc(REG_PRI1, 8'h08);
		rdc(REG_PRI2, 8'h11);
		$display("test priority done");
		test_done();
	end
endmodule : mcu_interrupt_flag_enable_bank_tb
`default_nettype wire
